// ---- design/acs_defines.vh ----
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
// register byte offsets on the apb slave
`define ACS_OFF_CLK_GATE 20'hF_00F0
`define ACS_OFF_CTRL0 20'h0_0000
`define ACS_OFF_CTRL1 20'h0_0004
`define ACS_OFF_CTRL2 20'h0_0008
`define ACS_OFF_RESULT 20'h0_000C
`define ACS_OFF_RESULT8 20'h0_0010
`define ACS_OFF_STATUS 20'h0_0014
// clock gate fields
`define ACS_GATE_SUPPLY 5
`define ACS_GATE_MASK 8'hBD
// control reg0 fields
`define ACS_C0_COMP_EN 0
`define ACS_C0_VS_LO 1
`define ACS_C0_VS_HI 2
`define ACS_C0_DIV_LO 3
`define ACS_C0_DIV_HI 5
`define ACS_C0_SCAN 6
`define ACS_C0_RUN 7
// control reg1 fields
`define ACS_C1_HW_TRIG 7
`define ACS_C1_HW_WAIT 6
`define ACS_C1_ONE_SHOT 5
// control reg2 fields
`define ACS_C2_MINUS_REF 1
`define ACS_C2_RES8 0
// timing
`define ACS_SETTLE_NS 1000
`define ACS_CLK_NS 50
`define ACS_SETTLE_CYC ((`ACS_SETTLE_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_STAB_FAD 8
`define ACS_SAMPLE_LONG 19
`define ACS_SAMPLE_SHORT 17
`define ACS_RES8_LESS 2
`define ACS_SCAN_LAST 2'h3
`define ACS_RESET_BYTE 8'h00
`endif

// ---- design/acs_divider.v ----
`include "acs_defines.vh"
`default_nettype none
// conversion clock: one-cycle tick every fclk/n, plus start delay lookup
module acs_divider (
  input wire i_mclk,          // system clock
  input wire i_nrst,          // sync reset, active low
  input wire i_run,           // divider running
  input wire [2:0] i_div_sel, // divider select
  output reg o_tick,          // conversion clock tick
  output reg [5:0] o_start_dly // first conversion start delay
);
  reg [5:0] cnt;
  reg [5:0] top;
  // divide ratio minus one, also the start delay in fclk
  always @* begin
    case (i_div_sel)
      3'h0: top = 6'h3F;
      3'h1: top = 6'h1F;
      3'h2: top = 6'h0F;
      3'h3: top = 6'h07;
      3'h4: top = 6'h05;
      3'h5: top = 6'h04;
      3'h6: top = 6'h03;
      default: top = 6'h01;
    endcase
  end
  ////////////////////////////////////////////////////////////
  // counter restarts whenever stopped so phase is repeatable
  always @(posedge i_mclk) begin
    if (!i_nrst || !i_run) begin
      cnt <= 6'h00;
      o_tick <= 1'b0;
    end else if (cnt == top) begin
      cnt <= 6'h00;
      o_tick <= 1'b1;
    end else begin
      cnt <= cnt + 6'h01;
      o_tick <= 1'b0;
    end
  end
  always @(posedge i_mclk) begin
    if (!i_nrst)
      o_start_dly <= 6'h00;
    else
      o_start_dly <= top;
  end
endmodule
`default_nettype wire

// ---- design/acs_sync.v ----
`default_nettype none
// two-flop synchroniser for the trigger pin
module acs_sync (
  input wire i_mclk, // system clock
  input wire i_nrst, // sync reset, active low
  input wire i_d,    // asynchronous level
  output reg o_q     // synchronised level
);
  reg meta;
  // first flop read only by the second
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      meta <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule
`default_nettype wire

// ---- design/acs_ctrl.v ----
// Notes on behaviour
// RL1: supply enable 0 holds converter in reset and blocks register writes.
// RL2: supply enable 0 forces converter registers to initial values.
// RL3: software writes 0 to clock gate bits 1 and 6.
// RL4: run bit reads 1 only while converting or stabilising in wait mode; here it also stays 1 between triggers in hardware no-wait mode.
// RL5: channel mode bit 0 selects single channel, 1 selects scan.
// RL6: comparator enable bit stops or runs the comparator.
// RL7: run/comparator pair decodes stopped, standby, converting; run-only prohibited.
// RL8: comparator settles 1 us; earlier run marks first result discardable.
// RL9: software changes divider and voltage mode only when fully stopped.
// RL10: software never sets run without comparator, nor both at once.
// RL11: run set by software write, or by trigger in wait mode.
// RL12: software and wait one-shot clear run after select or four channels.
// RL13: hardware no-wait one-shot keeps run set after conversion ends.
// RL14: software does not write run 1 in hardware wait mode.
// RL15: software changes comparator enable only while run is 0.
// RL16: divider picks fclk/64..2; start delay 63..1 clocks, 1 in wait mode.
// RL17: trigger skips start delay and stabilisation after first or channel 0.
// RL18: triggers spaced 2 clocks plus start and conversion time apart.
// RL19: minus reference select 1 picks external pin, 0 picks ground.
// RL20: done pulse raised once all conversions end and result loaded.
// RL21: scan mode converts channels 0 to 3 in turn.
// RL22: eight-bit resolution takes two fewer conversion clocks.
//
// Added by the designer: the APB register port.
`include "acs_defines.vh"
`default_nettype none
module acs_ctrl (
  input wire i_mclk,            // system clock, 20 MHz
  input wire i_nrst,            // sync reset, active low
  input wire i_psel,            // apb select
  input wire i_penable,         // apb enable
  input wire i_pwrite,          // apb direction
  input wire [19:0] i_paddr,    // apb byte address
  input wire [31:0] i_pwdata,   // apb write data
  output reg [31:0] o_prdata,   // apb read data
  output reg o_pready,          // apb ready
  output reg o_pslverr,         // apb error on unmapped address
  input wire i_hw_trigger,      // hardware trigger pin, async
  input wire i_sar_bit,         // comparator decision from analog
  output reg o_conv_reset,      // converter held in reset
  output reg o_comp_on,         // voltage comparator running
  output reg o_sample,          // sample and hold active
  output reg [1:0] o_channel,   // analog channel being converted
  output reg o_minus_ref_pin,   // minus reference from external pin
  output reg o_conv_done_irq    // conversion done pulse
);
  localparam ST_IDLE = 3'h0;
  localparam ST_STAB = 3'h1;
  localparam ST_START = 3'h2;
  localparam ST_SAMPLE = 3'h3;
  localparam ST_CONV = 3'h4;

  reg [7:0] clk_gate;
  reg [7:0] ctrl0;
  reg [7:0] ctrl1;
  reg [7:0] ctrl2;
  reg [9:0] result;
  reg [9:0] sar;
  reg [2:0] state;
  reg [5:0] cnt;
  reg [1:0] chan;
  reg first_bad;
  reg first_done;
  reg [4:0] settle;
  reg trig_q;
  wire trig_s;
  wire fad_tick;
  wire [5:0] start_dly;
  wire supply = clk_gate[`ACS_GATE_SUPPLY];
  wire run = ctrl0[`ACS_C0_RUN];
  wire comp = ctrl0[`ACS_C0_COMP_EN];
  wire scan = ctrl0[`ACS_C0_SCAN];
  wire hw = ctrl1[`ACS_C1_HW_TRIG];
  wire hw_wait = hw & ctrl1[`ACS_C1_HW_WAIT];
  wire one_shot = ctrl1[`ACS_C1_ONE_SHOT];
  wire res8 = ctrl2[`ACS_C2_RES8];
  wire wr = i_psel & i_penable & i_pwrite;
  wire trig_edge = trig_s & ~trig_q;
  wire [4:0] n_bits = res8 ? 5'h08 : 5'h0A;
  // sampling length follows the voltage/sampling mode low bit
  wire [4:0] n_samp = ctrl0[`ACS_C0_VS_LO] ? 5'h05 : 5'h07;

  // a mapped address decode used only for the error response in the setup phase
  function mapped;
    input [19:0] a;
    begin
      mapped = (a == `ACS_OFF_CLK_GATE) || (a == `ACS_OFF_CTRL0) ||
               (a == `ACS_OFF_CTRL1) || (a == `ACS_OFF_CTRL2) ||
               (a == `ACS_OFF_RESULT) || (a == `ACS_OFF_RESULT8) ||
               (a == `ACS_OFF_STATUS);
    end
  endfunction

  acs_sync u_sync (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_d(i_hw_trigger),
    .o_q(trig_s)
  );

  // divider runs only while stabilising, sampling or converting, not in the start state
  acs_divider u_div (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_run(state == ST_SAMPLE || state == ST_CONV || state == ST_STAB),
    .i_div_sel(ctrl0[`ACS_C0_DIV_HI:`ACS_C0_DIV_LO]),
    .o_tick(fad_tick),
    .o_start_dly(start_dly)
  );

  ////////////////////////////////////////////////////////////
  // clock gate register lives outside the gated domain
  always @(posedge i_mclk) begin
    if (!i_nrst)
      clk_gate <= `ACS_RESET_BYTE;
    // RL3: reserved bits masked
    else if (wr && i_paddr == `ACS_OFF_CLK_GATE)
      clk_gate <= i_pwdata[7:0] & `ACS_GATE_MASK;
  end

  always @(posedge i_mclk) begin
    trig_q <= i_nrst ? trig_s : 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // settle counter: comparator needs a microsecond after enable
  always @(posedge i_mclk) begin
    if (!i_nrst || !comp)
      settle <= 5'h00;
    else if (settle != `ACS_SETTLE_CYC)
      settle <= settle + 5'h01;
  end

  ////////////////////////////////////////////////////////////
  // control registers and sequencer share one process so the
  // run bit has a single driver for software and hardware
  always @(posedge i_mclk) begin
    o_conv_done_irq <= 1'b0;
    // RL1: gated off holds reset
    // RL2: force initial values
    if (!i_nrst || !supply) begin
      ctrl0 <= `ACS_RESET_BYTE;
      ctrl1 <= `ACS_RESET_BYTE;
      ctrl2 <= `ACS_RESET_BYTE;
      result <= 10'h000;
      sar <= 10'h000;
      state <= ST_IDLE;
      cnt <= 6'h00;
      chan <= 2'h0;
      first_bad <= 1'b0;
      first_done <= 1'b0;
    end else begin
      if (wr && i_paddr == `ACS_OFF_CTRL0) begin
        // RL11: software sets run
        // RL14: wait mode ignores a software 1
        // RL7: run without comparator refused
        ctrl0[`ACS_C0_RUN] <= i_pwdata[7] & ctrl0[`ACS_C0_COMP_EN] &
                              (~hw_wait | ~i_pwdata[7] | run);
        ctrl0[6:0] <= i_pwdata[6:0];
        // RL8: early run marks first result
        if (i_pwdata[7] && !run && !hw_wait)
          first_bad <= (settle != `ACS_SETTLE_CYC);
        if (i_pwdata[7] && !run) begin
          first_done <= 1'b0;
          chan <= 2'h0;
        end
      end
      if (wr && i_paddr == `ACS_OFF_CTRL1)
        ctrl1 <= i_pwdata[7:0];
      if (wr && i_paddr == `ACS_OFF_CTRL2)
        ctrl2 <= i_pwdata[7:0];
      // RL11: trigger sets run in wait mode
      if (hw_wait && comp && !run && trig_edge) begin
        ctrl0[`ACS_C0_RUN] <= 1'b1;
        first_done <= 1'b0;
        chan <= 2'h0;
      end
      case (state)
        ST_IDLE: begin
          // RL16: start delay per divider
          // RL17: trigger skips delay after first
          if (run && comp && (!hw || trig_edge)) begin
            if (hw_wait && !first_done) begin
              state <= ST_STAB;
              cnt <= 6'h00;
            end else begin
              state <= (first_done && hw) ? ST_SAMPLE : ST_START;
              // start state lasts cnt+1 clocks, so load one less than the delay
              cnt <= hw_wait ? 6'h00 : start_dly - 6'h01;
            end
          end else if (hw_wait && comp && !run && trig_edge) begin
            state <= ST_STAB;
            cnt <= 6'h00;
          end
        end
        ST_STAB: begin
          if (fad_tick) begin
            if (cnt == `ACS_STAB_FAD - 1) begin
              state <= ST_START;
              cnt <= 6'h00;
            end else
              cnt <= cnt + 6'h01;
          end
        end
        ST_START: begin
          if (cnt == 6'h00) begin
            state <= ST_SAMPLE;
            cnt <= 6'h00;
          end else
            cnt <= cnt - 6'h01;
        end
        ST_SAMPLE: begin
          if (fad_tick) begin
            if (cnt == {1'b0, n_samp} - 6'h01) begin
              state <= ST_CONV;
              cnt <= 6'h00;
              sar <= 10'h000;
            end else
              cnt <= cnt + 6'h01;
          end
        end
        ST_CONV: begin
          // RL22: eight bit is two clocks shorter
          if (fad_tick) begin
            sar[4'h9 - cnt[3:0]] <= i_sar_bit;
            if (cnt == {1'b0, n_bits} - 6'h01) begin
              result <= {sar[9:1], (cnt[3:0] == 4'h9) ? i_sar_bit : sar[0]};
              if (res8)
                result <= {sar[9:3], i_sar_bit, 2'b00};
              first_done <= 1'b1;
              first_bad <= 1'b0;
              cnt <= 6'h00;
              // RL21: scan walks channels 0..3
              if (scan && chan != `ACS_SCAN_LAST) begin
                chan <= chan + 2'h1;
                state <= hw ? ST_SAMPLE : ST_START;
              end else begin
                chan <= 2'h0;
                // RL20: done after all conversions
                o_conv_done_irq <= 1'b1;
                state <= ST_IDLE;
                // RL12: one-shot auto clear
                // RL13: no-wait hardware keeps run
                if (one_shot && !(hw && !hw_wait))
                  ctrl0[`ACS_C0_RUN] <= 1'b0;
              end
            end else
              cnt <= cnt + 6'h01;
          end
        end
        default: state <= ST_IDLE;
      endcase
      // software clear of run aborts the sequence
      if (wr && i_paddr == `ACS_OFF_CTRL0 && !i_pwdata[7] && state != ST_IDLE) begin
        state <= ST_IDLE;
        chan <= 2'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // apb slave: zero wait states, error on unmapped address
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~mapped(i_paddr);
      o_prdata <= 32'h0000_0000;
      if (i_psel && !i_penable && !i_pwrite) begin
        case (i_paddr)
          `ACS_OFF_CLK_GATE: o_prdata <= {24'h00_0000, clk_gate};
          // RL4: run readback is the live bit
          `ACS_OFF_CTRL0: o_prdata <= {24'h00_0000, ctrl0};
          `ACS_OFF_CTRL1: o_prdata <= {24'h00_0000, ctrl1};
          `ACS_OFF_CTRL2: o_prdata <= {24'h00_0000, ctrl2};
          `ACS_OFF_RESULT: o_prdata <= {16'h0000, result, 6'h00};
          `ACS_OFF_RESULT8: o_prdata <= {24'h00_0000, result[9:2]};
          `ACS_OFF_STATUS: o_prdata <= {27'h000_0000, first_bad, chan, 1'b0, state != ST_IDLE};
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // analog side controls, all registered
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_conv_reset <= 1'b1;
      o_comp_on <= 1'b0;
      o_sample <= 1'b0;
      o_channel <= 2'h0;
      o_minus_ref_pin <= 1'b0;
    end else begin
      o_conv_reset <= ~supply;
      // RL6: comparator follows enable
      o_comp_on <= comp;
      o_sample <= (state == ST_SAMPLE);
      // RL5: select converts channel 0 only
      o_channel <= scan ? chan : 2'h0;
      // RL19: minus reference choice
      o_minus_ref_pin <= ctrl2[`ACS_C2_MINUS_REF];
    end
  end
endmodule
`default_nettype wire

// ---- dv/acs_props.sv ----
`default_nettype none
module acs_props (
  input wire logic i_mclk, i_nrst, i_psel, i_penable, i_pwrite,
  input wire logic [19:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready, o_pslverr, o_conv_reset, o_comp_on, o_sample,
  input wire logic o_minus_ref_pin, o_conv_done_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // apb phases
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_wr(logic [19:0] a);
    i_psel && i_penable && i_pwrite && o_pready && i_paddr == a;
  endsequence
  ////////////////////////////////////////
  AST_READY: assert property (s_setup |=> o_pready) else $error("ready late");
  AST_READY_SRC: assert property (o_pready |-> i_psel && i_penable) else $error("stray ready");
  AST_ERR: assert property (o_pslverr |-> o_pready) else $error("error without ready");
  // registered outputs show a write two edges after it lands
  AST_GATE: assert property (
    s_wr(20'hF_00F0) |=> ##1 o_conv_reset == !$past(i_pwdata[5], 2)) else $error("gate wrong");
  AST_CLOSED: assert property (
    s_wr(20'h0_0000) ##0 o_conv_reset |=> ##1 !o_comp_on) else $error("write not blocked");
  AST_HOLD: assert property (
    o_conv_reset ##1 o_conv_reset |-> !o_comp_on && !o_sample) else $error("not held");
  AST_COMP: assert property (
    s_wr(20'h0_0000) ##0 (!o_conv_reset && !i_pwdata[7]) |=>
    ##1 o_comp_on == $past(i_pwdata[0], 2))
    else $error("comparator wrong");
  AST_MREF: assert property (
    s_wr(20'h0_0008) ##0 !o_conv_reset |=> ##1 o_minus_ref_pin == $past(i_pwdata[1], 2))
    else $error("minus ref wrong");
  AST_SAMPLE: assert property (o_sample |-> o_comp_on) else $error("sample w/o comp");
  AST_DONE: assert property (o_conv_done_irq |=> !o_conv_done_irq) else $error("long done");
endmodule
// checker sees the top ports only
bind acs_ctrl acs_props u_props (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_conv_reset(o_conv_reset),
  .o_comp_on(o_comp_on), .o_sample(o_sample), .o_minus_ref_pin(o_minus_ref_pin),
  .o_conv_done_irq(o_conv_done_irq));
`default_nettype wire

// ---- dv/acs_analog_model.sv ----
`default_nettype none
module acs_analog_model (
  input wire logic i_mclk,          // system clock
  input wire logic i_comp_on,       // comparator powered
  input wire logic [1:0] i_channel, // channel converted
  output logic o_sar_bit            // comparator decision
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip = 1'b0;
  // unpowered comparator has no stable answer, so it toggles
  always @(posedge i_mclk) flip <= ~flip;
  assign o_sar_bit = i_comp_on ? i_channel[0] : flip;
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 0, i_nrst = 0, psel = 0, pen = 0, pwr = 0, trig = 0, err;
  logic [19:0] pa = 0;
  localparam logic [19:0] A_GATE = 20'hF_00F0;
  localparam logic [19:0] A_C0 = 20'h0_0000;
  localparam logic [19:0] A_C1 = 20'h0_0004;
  localparam logic [19:0] A_C2 = 20'h0_0008;
  localparam logic [19:0] A_RES = 20'h0_000C;
  localparam logic [19:0] A_RES8 = 20'h0_0010;
  localparam logic [19:0] A_STAT = 20'h0_0014;
  localparam logic [19:0] A_NONE = 20'hF_00FC;
  logic [31:0] pwd = 0, prd, rd;
  logic pready, pslverr, crst, comp, samp, mref, done, sar;
  logic [1:0] chan;
  logic [3:0] seen;
  int miscompares = 0, comparisons = 0, cyc = 0;
  always #25 i_mclk = ~i_mclk;
  acs_ctrl dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(pready),
    .o_pslverr(pslverr), .i_hw_trigger(trig), .i_sar_bit(sar), .o_conv_reset(crst),
    .o_comp_on(comp), .o_sample(samp), .o_channel(chan), .o_minus_ref_pin(mref),
    .o_conv_done_irq(done));
  acs_analog_model u_ana (.i_mclk(i_mclk), .i_comp_on(comp), .i_channel(chan),
    .o_sar_bit(sar));
  ////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one apb transfer; waits an edge first so psel never changes twice at once
  task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
    int n;
    @(posedge i_mclk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge i_mclk);
    pen <= 1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prd;
    err = pslverr;
    check("pready", pready, 1);
    psel <= 0;
    pen <= 0;
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    apb(1, a, {24'h00_0000, d});
    // registered outputs follow two edges after the write lands
    repeat (2) @(posedge i_mclk);
  endtask
  task automatic rbit(input string name, input logic [19:0] a, input int b, input logic e);
    apb(0, a, 0);
    check(name, rd[b], e);
  endtask
  task automatic wait_done();
    int n;
    seen = 0;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge i_mclk);
      if (samp === 1'b1) seen[chan] = 1'b1;
      n++;
    end
    check("done", done, 1);
  endtask
  task automatic pulse_trigger();
    // one trigger per sequence, far apart
    @(posedge i_mclk);
    trig <= 1;
    repeat (4) @(posedge i_mclk);
    trig <= 0;
  endtask
  ////////////////////////////////////////
  task automatic t_closed();
    apb(0, A_GATE, 0);
    check("gate", rd, 0);
    check("conv_reset", crst, 1);
    wr(A_C0, 8'h01);
    apb(0, A_C0, 0);
    check("ctrl0", rd, 0);
    check("comp", comp, 0);
    apb(0, A_NONE, 0);
    check("slverr", err, 1);
  endtask
  task automatic t_open();
    // reserved gate bits written as 0
    wr(A_GATE, 8'h20);
    check("conv_reset", crst, 0);
    rbit("gate_b5", A_GATE, 5, 1);
    wr(A_C2, 8'h02);
    check("mref", mref, 1);
    wr(A_C2, 8'h00);
    check("mref", mref, 0);
    wr(A_C0, 8'hB8);
    rbit("run_nocomp", A_C0, 7, 0);
  endtask
  task automatic t_software();
    wr(A_C1, 8'h20);
    wr(A_C0, 8'h39);
    check("comp", comp, 1);
    repeat (20) @(posedge i_mclk);
    wr(A_C0, 8'hB9);
    rbit("run", A_C0, 7, 1);
    wait_done();
    check("select", seen, 4'h1);
    rbit("run_auto", A_C0, 7, 0);
    wr(A_C0, 8'hF9);
    wait_done();
    check("scan", seen, 4'hF);
    rbit("run_scan", A_C0, 7, 0);
    apb(0, A_RES, 0);
    check("result", rd, 32'h0000_FFC0);
    apb(0, A_RES8, 0);
    check("result8", rd, 32'h0000_00FF);
  endtask
  task automatic t_nowait();
    // comparator toggled only while run is 0
    wr(A_C0, 8'h38);
    wr(A_C1, 8'hA0);
    wr(A_C0, 8'h39);
    wr(A_C0, 8'hB9);
    rbit("run_sw", A_C0, 7, 1);
    rbit("early", A_STAT, 4, 1);
    pulse_trigger();
    wait_done();
    rbit("early_gone", A_STAT, 4, 0);
    rbit("run_kept", A_C0, 7, 1);
    wr(A_C0, 8'h39);
    rbit("run_wr0", A_C0, 7, 0);
  endtask
  task automatic t_wait();
    wr(A_C2, 8'h01);
    wr(A_C1, 8'hE0);
    wr(A_C0, 8'hF9);
    rbit("run_refused", A_C0, 7, 0);
    pulse_trigger();
    rbit("run_hw", A_C0, 7, 1);
    wait_done();
    check("scan_hw", seen, 4'hF);
    rbit("run_auto", A_C0, 7, 0);
    apb(0, A_RES, 0);
    check("result_8bit", rd, 32'h0000_FF00);
    // after the refused 1 above, only a 0 is written to run in wait mode
    wr(A_C0, 8'h39);
    rbit("standby", A_C0, 7, 0);
  endtask
  task automatic t_shut();
    wr(A_GATE, 8'h00);
    check("conv_reset", crst, 1);
    apb(0, A_C0, 0);
    check("ctrl0", rd, 0);
    apb(0, A_C1, 0);
    check("ctrl1", rd, 0);
    apb(0, A_RES, 0);
    check("result", rd, 0);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge i_mclk);
    i_nrst <= 1;
    t_closed();
    t_open();
    t_software();
    t_nowait();
    t_wait();
    t_shut();
    finish_test();
  end
  // hang guard, far above the expected run length
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
endmodule
`default_nettype wire
